// file: design/csr_lite_pkg.sv
package csr_lite_pkg;

  // Address, data and strobe widths of the write port.
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int PROT_W = 3;
  localparam int RESP_W = 2;

  // Number of word registers behind the port; a 7-bit byte address covers 32 words.
  localparam int NUM_REGS = 32;

  // Value of every control register after reset.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Write response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Cycles the master waits between finishing one write and offering the next.
  localparam logic [3:0] MASTER_GAP = 4'h0;

  // Device write states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_RESP = 2'b01
  } dev_state_t;

  // Master write states, Gray coded from idle to send to wait; wait back to idle flips both bits.
  typedef enum logic [1:0] {
    MST_IDLE = 2'b00,
    MST_SEND = 2'b01,
    MST_WAIT = 2'b11
  } mst_state_t;

endpackage

// file: design/csr_write_if.sv
`timescale 1ns/1ns
interface csr_write_if
  import csr_lite_pkg::*;
();
  logic [ADDR_W-1:0] awaddr;
  logic [PROT_W-1:0] awprot;
  logic              awvalid;
  logic              awready;
  logic [DATA_W-1:0] wdata;
  logic [STRB_W-1:0] wstrb;
  logic              wvalid;
  logic              wready;
  logic [RESP_W-1:0] bresp;
  logic              bvalid;
  logic              bready;

  modport device (
    input  awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
    output awready, wready, bresp, bvalid
  );

  modport master (
    output awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
    input  awready, wready, bresp, bvalid
  );
endinterface

// file: design/csr_write_slave.sv
`timescale 1ns/1ns
module csr_write_slave
  import csr_lite_pkg::*;
#(
  parameter int NumRegs = NUM_REGS
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  csr_write_if.device                       bus,
  output logic [NumRegs-1:0][DATA_W-1:0]    regsOut
);

  // Refuse a register count the address cannot reach.
  if (NumRegs < 1 || NumRegs > (1 << (ADDR_W - 2))) begin : g_bad_regs
    $error("NumRegs out of range");
  end

  dev_state_t        state_q;
  dev_state_t        state_d;
  logic              addrHeld_q;
  logic [ADDR_W-1:0] addr_q;
  logic [RESP_W-1:0] resp_q;
  logic [NumRegs-1:0][DATA_W-1:0] regs_q;

  wire               awFire;
  wire               wFire;
  wire               bFire;
  wire [ADDR_W-1:0]  wrAddr;
  wire [ADDR_W-3:0]  wordIdx;
  wire               inRange;
  wire               aligned;
  wire [DATA_W-1:0]  byteMask;

  // Address is taken in idle while no address is held; data once an address is
  // held or arrives in the same cycle; awprot is never looked at.
  assign bus.awready = (state_q == DEV_IDLE) && !addrHeld_q;
  assign bus.wready  = (state_q == DEV_IDLE) && (addrHeld_q || bus.awvalid);
  assign awFire      = bus.awvalid && bus.awready;
  assign wFire       = bus.wvalid && bus.wready;
  assign bFire       = bus.bvalid && bus.bready;
  assign wrAddr      = addrHeld_q ? addr_q : bus.awaddr;
  assign wordIdx     = wrAddr[ADDR_W-1:2];
  assign inRange     = 32'(wordIdx) < 32'(NumRegs);
  assign aligned     = wrAddr[1:0] == 2'h0;

  // Byte enables expand to a bit mask, one generate step per lane.
  for (genvar b = 0; b < STRB_W; b++) begin : g_lane
    assign byteMask[b*8 +: 8] = {8{bus.wstrb[b]}};
  end

  // Response is held until accepted.
  assign bus.bvalid = (state_q == DEV_RESP);
  assign bus.bresp  = resp_q;
  assign regsOut    = regs_q;

  // Next state: one response per address-and-data pair.
  always_comb begin
    state_d = state_q;
    case (state_q)
      DEV_IDLE: begin
        if (wFire) begin
          state_d = DEV_RESP;
        end
      end
      DEV_RESP: begin
        if (bFire) begin
          state_d = DEV_IDLE;
        end
      end
      default: begin
        state_d = DEV_IDLE;
      end
    endcase
  end

  // Handshake state, captured address and response code.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= DEV_IDLE;
      addrHeld_q <= 1'b0;
      addr_q     <= '0;
      resp_q     <= RESP_OKAY;
    end else begin
      state_q <= state_d;
      if (awFire && !wFire) begin
        addrHeld_q <= 1'b1;
        addr_q     <= bus.awaddr;
      end else if (wFire) begin
        addrHeld_q <= 1'b0;
      end
      if (wFire) begin
        resp_q <= (inRange && aligned) ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // Register file: strobed bytes merge into the addressed word.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regs_q <= {NumRegs{REG_RESET}};
    end else if (wFire && inRange && aligned) begin
      regs_q[wordIdx] <=
        (regs_q[wordIdx] & ~byteMask) | (bus.wdata & byteMask);
    end
  end

endmodule

// file: design/csr_write_master.sv
`timescale 1ns/1ns
module csr_write_master
  import csr_lite_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  csr_write_if.master            bus,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqData,
  input  wire logic [STRB_W-1:0] reqStrb,
  output logic                   doneValid,
  output logic [RESP_W-1:0]      doneResp
);

  mst_state_t        state_q;
  mst_state_t        state_d;
  logic              awPend_q;
  logic              wPend_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [STRB_W-1:0] strb_q;
  logic [RESP_W-1:0] resp_q;
  logic              done_q;

  wire reqFire;
  wire awFire;
  wire wFire;
  wire bFire;

  // Address and data are offered from held copies and stay stable until taken.
  assign reqReady    = (state_q == MST_IDLE);
  assign reqFire     = reqValid && reqReady;
  assign bus.awaddr  = addr_q;
  assign bus.awprot  = '0;
  assign bus.awvalid = awPend_q;
  assign bus.wdata   = data_q;
  assign bus.wstrb   = strb_q;
  assign bus.wvalid  = wPend_q;
  assign bus.bready  = (state_q == MST_WAIT);
  assign awFire      = bus.awvalid && bus.awready;
  assign wFire       = bus.wvalid && bus.wready;
  assign bFire       = bus.bvalid && bus.bready;
  assign doneValid   = done_q;
  assign doneResp    = resp_q;

  // Next state: send both halves, then wait for the response.
  always_comb begin
    state_d = state_q;
    case (state_q)
      MST_IDLE: begin
        if (reqFire) begin
          state_d = MST_SEND;
        end
      end
      MST_SEND: begin
        if ((!awPend_q || awFire) && (!wPend_q || wFire)) begin
          state_d = MST_WAIT;
        end
      end
      MST_WAIT: begin
        if (bFire) begin
          state_d = MST_IDLE;
        end
      end
      default: begin
        state_d = MST_IDLE;
      end
    endcase
  end

  // Request capture, valid flags and response report.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= MST_IDLE;
      awPend_q <= 1'b0;
      wPend_q  <= 1'b0;
      addr_q   <= '0;
      data_q   <= '0;
      strb_q   <= '0;
      resp_q   <= RESP_OKAY;
      done_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= bFire;
      if (reqFire) begin
        addr_q   <= reqAddr;
        data_q   <= reqData;
        strb_q   <= reqStrb;
        awPend_q <= 1'b1;
        wPend_q  <= 1'b1;
      end else begin
        if (awFire) begin
          awPend_q <= 1'b0;
        end
        if (wFire) begin
          wPend_q <= 1'b0;
        end
      end
      if (bFire) begin
        resp_q <= bus.bresp;
      end
    end
  end

endmodule

// file: tb/csr_write_sva.sv
`timescale 1ns/1ns
module csr_write_sva
  import csr_lite_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [RESP_W-1:0] bresp,
  input wire logic              bvalid,
  input wire logic              bready
);
  logic addrHeld_q;
  wire  misaligned = awaddr[1:0] != 2'h0;
  wire  dataTake   = wvalid && wready;
  // Remembers an address taken ahead of its data.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) addrHeld_q <= 1'b0;
    else if (dataTake) addrHeld_q <= 1'b0;
    else if (awvalid && awready) addrHeld_q <= 1'b1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("response dropped early");
  property p_bafter; dataTake |=> bvalid; endproperty
  a_bafter: assert property (p_bafter) else $error("no response after data");
  property p_busy; bvalid |-> !awready && !wready; endproperty
  a_busy: assert property (p_busy) else $error("accepted while busy");
  property p_needaddr; dataTake |-> addrHeld_q || awvalid; endproperty
  a_needaddr: assert property (p_needaddr) else $error("data without address");
  property p_oneaddr; addrHeld_q |-> !awready; endproperty
  a_oneaddr: assert property (p_oneaddr) else $error("second address taken");
  property p_idle; !bvalid && !addrHeld_q |-> awready; endproperty
  a_idle: assert property (p_idle) else $error("idle but not ready");
  property p_code;
    dataTake && awvalid |=> bresp == ($past(misaligned) ? RESP_DECERR : RESP_OKAY);
  endproperty
  a_code: assert property (p_code) else $error("wrong response code");
  property p_once; bvalid && bready |=> !bvalid; endproperty
  a_once: assert property (p_once) else $error("response repeated");
  c_write: cover property (dataTake && awvalid);
  c_stall: cover property (bvalid && !bready);
  c_decode: cover property (bvalid && bresp == RESP_DECERR);
endmodule

// file: tb/gate_subst_csr_lite_write_port_tb.sv
`timescale 1ns/1ns
module gate_subst_csr_lite_write_port_tb;
  import csr_lite_pkg::*;
  logic                            ref_clk = 1'b0;
  logic                            rst_n = 1'b0;
  logic                            reqValid = 1'b0;
  logic                            reqReady;
  logic [ADDR_W-1:0]               reqAddr = '0;
  logic [DATA_W-1:0]               reqData = '0;
  logic [STRB_W-1:0]               reqStrb = '0;
  logic                            doneValid;
  logic [RESP_W-1:0]               doneResp;
  logic [NUM_REGS-1:0][DATA_W-1:0] regsA;
  logic [NUM_REGS-1:0][DATA_W-1:0] regsB;
  logic [DATA_W-1:0]               model [NUM_REGS];
  int                              failures = 0;
  int                              checksDone = 0;
  csr_write_if busA();
  csr_write_if busB();
  csr_write_master u_csr_write_master (.ref_clk(ref_clk), .rst_n(rst_n), .bus(busA),
    .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr), .reqData(reqData),
    .reqStrb(reqStrb), .doneValid(doneValid), .doneResp(doneResp));
  csr_write_slave u_csr_write_slave (.ref_clk(ref_clk), .rst_n(rst_n), .bus(busA),
    .regsOut(regsA));
  csr_write_slave u_csr_write_slave_b (.ref_clk(ref_clk), .rst_n(rst_n), .bus(busB),
    .regsOut(regsB));
  csr_write_sva u_csr_write_sva (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(busA.awaddr),
    .awvalid(busA.awvalid), .awready(busA.awready), .wvalid(busA.wvalid),
    .wready(busA.wready), .bresp(busA.bresp), .bvalid(busA.bvalid), .bready(busA.bready));
  // Free-running 50 MHz clock.
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check_regs();
    for (int i = 0; i < NUM_REGS; i++) check(regsA[i], model[i]);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (model[i]) model[i] = REG_RESET;
    check_regs();
  endtask
  // One write through the master end, then its response and every register are judged.
  task automatic write(input logic [6:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] r);
    int n;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqData <= d;
    reqStrb <= s;
    n = 0;
    do @(posedge ref_clk); while (reqReady !== 1'b1 && ++n < 20);
    reqValid <= 1'b0;
    do @(posedge ref_clk); while (doneValid !== 1'b1 && ++n < 40);
    check({31'h0, doneValid}, 32'h1);
    check({30'h0, doneResp}, {30'h0, r});
    for (int i = 0; i < 4; i++) if (s[i] && r == RESP_OKAY) model[a[6:2]][8*i +: 8] = d[8*i +: 8];
    check_regs();
  endtask
  // Data offered before its address on the second port, response stalled by the master side.
  task automatic late_addr();
    @(posedge ref_clk);
    busB.wvalid <= 1'b1;
    busB.wdata <= 32'hA5A5_5A5A;
    busB.awaddr <= 7'h13;
    repeat (3) @(posedge ref_clk) check({31'h0, busB.bvalid}, 32'h0);
    busB.awvalid <= 1'b1;
    busB.awaddr <= 7'h10;
    @(posedge ref_clk);
    check({30'h0, busB.awready, busB.wready}, 32'h3);
    busB.awvalid <= 1'b0;
    busB.wvalid <= 1'b0;
    busB.awaddr <= 7'h6F;
    busB.wdata <= 32'h5A5A_A5A5;
    repeat (3) @(posedge ref_clk) check({29'h0, busB.bvalid, busB.bresp}, 32'h4);
    busB.bready <= 1'b1;
    @(posedge ref_clk);
    busB.bready <= 1'b0;
    @(posedge ref_clk);
    check({31'h0, busB.bvalid}, 32'h0);
    check(regsB[4], 32'hA5A5_5A5A);
  endtask
  // Main sequence.
  initial begin
    busB.awvalid = 1'b0;
    busB.wvalid = 1'b0;
    busB.bready = 1'b0;
    busB.awprot = 3'h7;
    busB.wstrb = 4'hF;
    busB.awaddr = 7'h00;
    busB.wdata = 32'h0;
    do_reset();
    write(7'h04, 32'h1234_5678, 4'hF, RESP_OKAY);
    for (int n = 0; n < 4; n++) write(7'h08, 32'h1111_1111 * (n + 1), 4'h1 << n, RESP_OKAY);
    write(7'h7C, 32'hCAFE_F00D, 4'hF, RESP_OKAY);
    write(7'h05, 32'hFFFF_FFFF, 4'hF, RESP_DECERR);
    do_reset();
    late_addr();
    complete_run();
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule
